// ### crc_pkg.sv
`default_nettype none
package crc_pkg;
  // ----------------------------------------
  // Register indices (word addresses)
  // ----------------------------------------
  localparam logic [3:0] ADDR_CONTROL_ONE = 4'h0;
  localparam logic [3:0] ADDR_CONTROL_TWO = 4'h1;
  localparam logic [3:0] ADDR_POLY_LOW = 4'h2;
  localparam logic [3:0] ADDR_POLY_HIGH = 4'h3;
  localparam logic [3:0] ADDR_DATA_LOW = 4'h4;
  localparam logic [3:0] ADDR_DATA_HIGH = 4'h5;
  localparam logic [3:0] ADDR_RESULT_LOW = 4'h6;
  localparam logic [3:0] ADDR_RESULT_HIGH = 4'h7;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h8;
  localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h9;
  localparam logic [3:0] ADDR_IRQ_CLEAR = 4'ha;
  // ----------------------------------------
  // Control one field positions
  // ----------------------------------------
  localparam int BIT_MODULE_ENABLE = 15;
  localparam int BIT_IDLE_STOP = 13;
  localparam int BIT_COUNT_HI = 12;
  localparam int BIT_COUNT_LO = 8;
  localparam int BIT_FULL = 7;
  localparam int BIT_EMPTY = 6;
  localparam int BIT_IRQ_SELECT = 5;
  localparam int BIT_GO = 4;
  localparam int BIT_LSB_FIRST = 3;
  // Control two: poly length in 12:8, data width minus one in 4:0
  localparam int BIT_POLY_LENGTH_LO = 8;
  localparam int BIT_DWIDTH_LO = 0;
  localparam logic [15:0] CONTROL_TWO_RESET = 16'h0000;
  // Irq status bits
  localparam int IRQ_EMPTY = 0;
  localparam int IRQ_DONE = 1;
  localparam logic [4:0] FIFO_DEPTH_SHORT = 5'h10;
  localparam logic [4:0] FIFO_DEPTH_LONG = 5'h08;
  localparam logic [4:0] POLY_LENGTH_SHORT_MAX = 5'h07;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOAD = 2'b01,
    ST_SHIFT = 2'b10
  } eng_state_type;
endpackage
`default_nettype wire

// ### crc_engine_control_status.sv
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Eight CRC registers: two controls, polynomial, input data, result pairs.
// - Each set polynomial bit up to the poly length puts that term into the feedback.
// - Input pair buffers double words into FIFO; result pair holds CRC.
// - Idle-stop bit 13 halts engine in Idle mode when set.
// - Full flag bit 7, empty flag bit 6, read-only; empty reads one at reset.
// - Go bit 4 starts shifter; clearing stops it once the current word is shifted; hardware may clear it.
// - Bit 3 set feeds words LSB first, clear feeds MSB first.
// - Engine clears go by itself when calculation completes.
// - Direction affects input only; result stays a normal CRC.
module crc_engine_control_status
  import crc_pkg::*;
#(
  parameter int DATA_WIDTH = 16,
  parameter int FIFO_SLOTS = 16
)(
  input wire logic clock,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic idle_mode,
  output logic [15:0] rdata,
  output logic irq
);
  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  // FIFO and shifter are sized for 16-bit words and 16 slots only
  if (DATA_WIDTH != 16 || FIFO_SLOTS != 16)
  begin : g_bad_params
    $error("crc_engine_control_status supports only 16-bit words, 16 slots");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic module_enable;
    logic idle_stop;
    logic irq_select;
    logic shifter_go;
    logic lsb_first_select;
    logic [15:0] control_two;
    logic [31:0] poly;
    logic [31:0] result;
    logic [15:0] data_low;
    logic [15:0][31:0] fifo;
    logic [3:0] rd_ptr;
    logic [3:0] wr_ptr;
    logic [4:0] count;
    eng_state_type state;
    logic [31:0] shreg;
    logic [5:0] bits_left;
    logic [1:0] irq_status;
    logic [1:0] irq_enable;
    logic [15:0] rdata;
  } state_type;

  state_type cur_r, cur_nxt;

  function automatic logic [4:0] fifo_max(input logic [4:0] poly_length);
    fifo_max = (poly_length > POLY_LENGTH_SHORT_MAX) ? FIFO_DEPTH_LONG : FIFO_DEPTH_SHORT;
  endfunction

  function automatic logic [31:0] crc_step(input logic [31:0] crc, input logic din,
                                           input logic [31:0] poly, input logic [4:0] poly_length);
    logic fb;
    logic [31:0] nx;
    fb = crc[poly_length] ^ din;
    nx = {crc[30:0], 1'b0};
    if (fb)
      nx = nx ^ poly;
    for (int i = 0; i < 32; i++)
      if (i > int'(poly_length))
        nx[i] = 1'b0;
    crc_step = nx;
  endfunction

  logic [4:0] poly_length;
  logic [4:0] dwid;
  logic [4:0] max_words;
  logic full;
  logic empty;
  logic run;
  logic done_evt;
  logic empty_evt;
  logic [31:0] fifo_head;

  assign poly_length = cur_r.control_two[BIT_POLY_LENGTH_LO +: 5];
  assign dwid = cur_r.control_two[BIT_DWIDTH_LO +: 5];
  assign max_words = fifo_max(poly_length);
  assign full = (cur_r.count >= max_words);
  assign empty = (cur_r.count == 5'h00);
  assign run = cur_r.module_enable && !(cur_r.idle_stop && idle_mode);
  assign fifo_head = cur_r.fifo[cur_r.rd_ptr];

  always_comb
  begin
    cur_nxt = cur_r;
    done_evt = 1'b0;
    empty_evt = 1'b0;
    cur_nxt.rdata = 16'h0000;
    // ----------------------------------------
    // Engine
    // ----------------------------------------
    if (run)
    begin
      case (cur_r.state)
        ST_IDLE:
        begin
          if (cur_r.shifter_go)
            cur_nxt.state = ST_LOAD;
        end
        ST_LOAD:
        begin
          if (!cur_r.shifter_go)
            cur_nxt.state = ST_IDLE;
          else if (!empty)
          begin
            cur_nxt.shreg = fifo_head;
            cur_nxt.bits_left = {1'b0, dwid} + 6'h01;
            cur_nxt.rd_ptr = cur_r.rd_ptr + 4'h1;
            cur_nxt.count = cur_r.count - 5'h01;
            if (cur_r.count == 5'h01)
              empty_evt = 1'b1;
            cur_nxt.state = ST_SHIFT;
          end
          else
          begin
            // Nothing left to shift: the calculation is complete
            cur_nxt.shifter_go = 1'b0;
            done_evt = 1'b1;
            cur_nxt.state = ST_IDLE;
          end
        end
        ST_SHIFT:
        begin
          // Bit order only steers input; the result register stays unreflected
          cur_nxt.result = crc_step(cur_r.result, cur_r.lsb_first_select ?
            cur_r.shreg[0] : cur_r.shreg[dwid], cur_r.poly, poly_length);
          cur_nxt.shreg = cur_r.lsb_first_select ? {1'b0, cur_r.shreg[31:1]} :
            {cur_r.shreg[30:0], 1'b0};
          cur_nxt.bits_left = cur_r.bits_left - 6'h01;
          if (cur_r.bits_left == 6'h01)
            cur_nxt.state = ST_LOAD;
        end
        default: cur_nxt.state = ST_IDLE;
      endcase
    end

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    if (wr_en)
    begin
      case (addr)
        ADDR_CONTROL_ONE:
        begin
          cur_nxt.module_enable = wdata[BIT_MODULE_ENABLE];
          cur_nxt.idle_stop = wdata[BIT_IDLE_STOP];
          cur_nxt.irq_select = wdata[BIT_IRQ_SELECT];
          // A hardware clear in this cycle loses to a software set
          cur_nxt.shifter_go = wdata[BIT_GO];
          cur_nxt.lsb_first_select = wdata[BIT_LSB_FIRST];
        end
        ADDR_CONTROL_TWO: cur_nxt.control_two = wdata;
        ADDR_POLY_LOW: cur_nxt.poly[15:0] = wdata;
        ADDR_POLY_HIGH: cur_nxt.poly[31:16] = wdata;
        ADDR_DATA_LOW: cur_nxt.data_low = wdata;
        ADDR_DATA_HIGH:
        begin
          // High half completes a double word and pushes it; dropped when full
          if (!full)
          begin
            cur_nxt.fifo[cur_r.wr_ptr] = {wdata, cur_r.data_low};
            cur_nxt.wr_ptr = cur_r.wr_ptr + 4'h1;
            cur_nxt.count = cur_nxt.count + 5'h01;
            // A word landing in the pop cycle keeps the count from reaching zero
            empty_evt = 1'b0;
          end
        end
        ADDR_RESULT_LOW: cur_nxt.result[15:0] = wdata;
        ADDR_RESULT_HIGH: cur_nxt.result[31:16] = wdata;
        ADDR_IRQ_ENABLE: cur_nxt.irq_enable = wdata[1:0];
        ADDR_IRQ_CLEAR: cur_nxt.irq_status = cur_r.irq_status & ~wdata[1:0];
        default: ;
      endcase
    end

    // Set wins over a clear in the same cycle
    if (empty_evt)
      cur_nxt.irq_status[IRQ_EMPTY] = 1'b1;
    if (done_evt)
      cur_nxt.irq_status[IRQ_DONE] = 1'b1;

    // Disabled module resets its pointers, data and engine
    if (!cur_nxt.module_enable)
    begin
      cur_nxt.state = ST_IDLE;
      cur_nxt.rd_ptr = 4'h0;
      cur_nxt.wr_ptr = 4'h0;
      cur_nxt.count = 5'h00;
      cur_nxt.data_low = 16'h0000;
      cur_nxt.result = 32'h0000_0000;
      cur_nxt.shifter_go = 1'b0;
    end

    // ----------------------------------------
    // Register reads
    // ----------------------------------------
    if (rd_en)
    begin
      case (addr)
        ADDR_CONTROL_ONE:
          cur_nxt.rdata = {cur_r.module_enable, 1'b0, cur_r.idle_stop, cur_r.count,
            full, empty, cur_r.irq_select, cur_r.shifter_go,
            cur_r.lsb_first_select, 3'b000};
        ADDR_CONTROL_TWO: cur_nxt.rdata = cur_r.control_two;
        ADDR_POLY_LOW: cur_nxt.rdata = cur_r.poly[15:0];
        ADDR_POLY_HIGH: cur_nxt.rdata = cur_r.poly[31:16];
        ADDR_DATA_LOW: cur_nxt.rdata = cur_r.data_low;
        ADDR_DATA_HIGH: cur_nxt.rdata = 16'h0000;
        ADDR_RESULT_LOW: cur_nxt.rdata = cur_r.result[15:0];
        ADDR_RESULT_HIGH: cur_nxt.rdata = cur_r.result[31:16];
        ADDR_IRQ_STATUS: cur_nxt.rdata = {14'h0000, cur_r.irq_status};
        ADDR_IRQ_ENABLE: cur_nxt.rdata = {14'h0000, cur_r.irq_enable};
        default: cur_nxt.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      cur_r <= '{control_two: CONTROL_TWO_RESET, state: ST_IDLE, default: '0};
    else
      cur_r <= cur_nxt;
  end

  assign rdata = cur_r.rdata;
  // Select chooses which sticky event may drive the line
  assign irq = cur_r.irq_select ? (cur_r.irq_status[IRQ_EMPTY] & cur_r.irq_enable[IRQ_EMPTY])
    : (cur_r.irq_status[IRQ_DONE] & cur_r.irq_enable[IRQ_DONE]);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_go_cleared_on_done;
    @(posedge clock) disable iff (rst)
    done_evt && !wr_en |=> !cur_r.shifter_go && cur_r.irq_status[IRQ_DONE];
  endproperty
  a_go_cleared_on_done: assert property (p_go_cleared_on_done)
    else $error("go not cleared at completion");

  property p_count_bounded;
    @(posedge clock) disable iff (rst)
    cur_r.count <= max_words || cur_r.count <= $past(cur_r.count);
  endproperty
  a_count_bounded: assert property (p_count_bounded)
    else $error("fifo count above limit");

  property p_empty_flag;
    @(posedge clock) disable iff (rst)
    rd_en && addr == ADDR_CONTROL_ONE |=> rdata[BIT_EMPTY] == ($past(cur_r.count) == 5'h00);
  endproperty
  a_empty_flag: assert property (p_empty_flag)
    else $error("empty flag mismatch");

  property p_reserved_zero;
    @(posedge clock) disable iff (rst)
    rd_en && addr == ADDR_CONTROL_ONE |=> rdata[14] == 1'b0 && rdata[2:0] == 3'b000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("unimplemented bits not zero");

  property p_idle_halts;
    @(posedge clock) disable iff (rst)
    cur_r.idle_stop && idle_mode && !wr_en |=> $stable(cur_r.result) && $stable(cur_r.state);
  endproperty
  a_idle_halts: assert property (p_idle_halts)
    else $error("engine ran while stopped in idle");

  property p_push;
    @(posedge clock) disable iff (rst)
    wr_en && addr == ADDR_DATA_HIGH && !full && cur_r.module_enable && cur_r.state != ST_LOAD
    |=> cur_r.count == $past(cur_r.count) + 5'h01;
  endproperty
  a_push: assert property (p_push)
    else $error("push did not raise count");

  property p_irq_select;
    @(posedge clock) disable iff (rst)
    cur_r.irq_select && !cur_r.irq_enable[IRQ_EMPTY] |-> !irq;
  endproperty
  a_irq_select: assert property (p_irq_select)
    else $error("irq raised by unselected source");

  property p_go_starts;
    @(posedge clock) disable iff (rst)
    cur_r.state == ST_IDLE && cur_r.shifter_go && run && !wr_en |=> cur_r.state == ST_LOAD;
  endproperty
  a_go_starts: assert property (p_go_starts)
    else $error("go did not start the shifter");

  property p_rdata_quiet;
    @(posedge clock) disable iff (rst)
    !rd_en |=> rdata == 16'h0000;
  endproperty
  a_rdata_quiet: assert property (p_rdata_quiet)
    else $error("read data not zero outside a read");

  property p_empty_sets_status;
    @(posedge clock) disable iff (rst)
    empty_evt |=> cur_r.irq_status[IRQ_EMPTY];
  endproperty
  a_empty_sets_status: assert property (p_empty_sets_status)
    else $error("fifo emptied without status bit");

  property p_done_needs_go;
    @(posedge clock) disable iff (rst)
    done_evt |-> cur_r.shifter_go && cur_r.state == ST_LOAD;
  endproperty
  a_done_needs_go: assert property (p_done_needs_go)
    else $error("completion without a running shifter");

  property p_disabled_idle;
    @(posedge clock) disable iff (rst)
    !cur_r.module_enable |-> cur_r.count == 5'h00 && cur_r.state == ST_IDLE && !cur_r.shifter_go;
  endproperty
  a_disabled_idle: assert property (p_disabled_idle)
    else $error("disabled module holds words or runs");

  c_done: cover property (@(posedge clock) disable iff (rst) done_evt);
  c_empty: cover property (@(posedge clock) disable iff (rst) empty_evt);
  c_full: cover property (@(posedge clock) disable iff (rst) full);
  c_lsb: cover property (@(posedge clock) disable iff (rst)
    cur_r.state == ST_SHIFT && cur_r.lsb_first_select);
  c_idle_hold: cover property (@(posedge clock) disable iff (rst)
    cur_r.idle_stop && idle_mode && cur_r.shifter_go);
endmodule // crc_engine_control_status
`default_nettype wire

// ### crc_engine_control_status_bench.sv
`timescale 1ns/1ps
`default_nettype none
module crc_engine_control_status_bench
  import crc_pkg::*;
;
  typedef struct packed {logic [3:0] a; logic [15:0] d; logic [15:0] e;} row_type;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic idle_mode = 1'b0;
  logic [15:0] rdata;
  logic irq;
  int err_count = 0;
  int samples_checked = 0;
  logic [15:0] v, r1, r2, r3;
  row_type rows [9] = '{
    '{ADDR_CONTROL_ONE, 16'hffef, 16'ha068},
    '{ADDR_CONTROL_ONE, 16'h8000, 16'h8040},
    '{ADDR_CONTROL_TWO, 16'h1f1f, 16'h1f1f},
    '{ADDR_POLY_LOW, 16'h1021, 16'h1021},
    '{ADDR_POLY_HIGH, 16'h8005, 16'h8005},
    '{ADDR_IRQ_STATUS, 16'hffff, 16'h0000},
    '{ADDR_IRQ_ENABLE, 16'h0003, 16'h0003},
    '{ADDR_IRQ_CLEAR, 16'h0003, 16'h0000},
    '{4'hf, 16'hffff, 16'h0000}};

  crc_engine_control_status #(.DATA_WIDTH(16), .FIFO_SLOTS(16)) u_crc_engine_control_status (
    .clock(clock),
    .rst(rst),
    .addr(addr),
    .wdata(wdata),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .idle_mode(idle_mode),
    .rdata(rdata),
    .irq(irq)
  );

  always #5 clock = ~clock;

  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Leading edge wait keeps back-to-back calls from driving a strobe twice in one step
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] q);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1;
    q = rdata;
  endtask

  // Disable first so every run starts from an empty FIFO and a cleared result
  task automatic fill(input logic [4:0] poly_length, input int n, input logic [15:0] w);
    wr(ADDR_CONTROL_ONE, 16'h0000);
    wr(ADDR_CONTROL_ONE, 16'h8000);
    wr(ADDR_CONTROL_TWO, {3'h0, poly_length, 8'h0f});
    for (int i = 0; i < n; i++)
    begin
      wr(ADDR_DATA_LOW, w);
      wr(ADDR_DATA_HIGH, w);
    end
  endtask

  task automatic crc(input logic [15:0] ctrl, input logic [15:0] w, input logic [15:0] p,
                     input logic [15:0] ien, output logic [15:0] q);
    logic [15:0] s;
    fill(5'h0f, 1, w);
    wr(ADDR_POLY_LOW, p);
    wr(ADDR_POLY_HIGH, 16'h0000);
    wr(ADDR_RESULT_LOW, 16'h0000);
    wr(ADDR_RESULT_HIGH, 16'h0000);
    wr(ADDR_IRQ_CLEAR, 16'h0003);
    wr(ADDR_IRQ_ENABLE, ien);
    wr(ADDR_CONTROL_ONE, ctrl);
    if (ctrl[BIT_IDLE_STOP])
    begin
      repeat (60) @(posedge clock);
      rd(ADDR_CONTROL_ONE, s);
      chk("go_held_in_idle", 16'(s[BIT_GO]), 16'h0001);
      idle_mode <= 1'b0;
    end
    s = 16'hffff;
    for (int k = 0; k < 100 && s[BIT_GO] !== 1'b0; k++)
      rd(ADDR_CONTROL_ONE, s);
    chk("ctrl_after_done", s, (ctrl & 16'hffef) | 16'h0040);
    rd(ADDR_IRQ_STATUS, s);
    chk("status_after_done", s, 16'h0003);
    rd(ADDR_RESULT_LOW, q);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    rd(ADDR_CONTROL_ONE, v);
    chk("ctrl_one_reset", v, 16'h0040);
    chk("irq_reset", 16'(irq), 16'h0000);
    for (int i = 0; i < 9; i++)
    begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, v);
      chk("table_row", v, rows[i].e);
    end
    fill(5'h10, 9, 16'h00f1);
    rd(ADDR_CONTROL_ONE, v);
    chk("count_long_poly", v, 16'h8880);
    fill(5'h07, 17, 16'h00f1);
    rd(ADDR_CONTROL_ONE, v);
    chk("count_short_poly", v, 16'h9080);
    // Idle without idle-stop must not hold the engine
    idle_mode <= 1'b1;
    crc(16'h8010, 16'h00f1, 16'h1021, 16'h0001, r1);
    chk("irq_done_select_masked", 16'(irq), 16'h0000);
    chk("crc_value", r1, 16'hff3e);
    crc(16'h8038, 16'h8f00, 16'h1021, 16'h0001, r2);
    chk("irq_empty_select", 16'(irq), 16'h0001);
    chk("lsb_first_result", r2, r1);
    wr(ADDR_IRQ_CLEAR, 16'h0001);
    repeat (3) @(posedge clock);
    chk("irq_after_clear", 16'(irq), 16'h0000);
    crc(16'ha010, 16'h00f1, 16'h8005, 16'h0002, r3);
    chk("poly_changes_result", 16'(r3 !== r1), 16'h0001);
    chk("crc_value_other_poly", r3, 16'h8225);
    chk("irq_done_select", 16'(irq), 16'h0001);
    wr(ADDR_IRQ_ENABLE, 16'h0000);
    repeat (3) @(posedge clock);
    chk("irq_masked", 16'(irq), 16'h0000);
    close_out();
  end

  // Whole run needs well under a tenth of this span
  initial
  begin
    #200000;
    err_count++;
    close_out();
  end
endmodule // crc_engine_control_status_bench
`default_nettype wire
